// file: common/bpdd_pkg.sv
// Constants, register map and types of the bridge PWM output stage.
//
// Operation
// - Half-bridge inactive-to-active edges are delayed by the deadband count.
// - Full-bridge direction change takes effect at the next PWM cycle.
// - Non-modulated outputs switch early by 1, 4 or 16 oscillator periods.
// - Modulated outputs stay inactive during the direction transition.
// - Full-bridge modes insert no deadband delay.
// - Direction writes anywhere in a cycle do not corrupt that cycle.
// - All four output latches are correct after one full cycle.
// - Completion of a full cycle sets the period flag.
// - Polarity field picks output levels; mode field picks output mode.
// - Ten-bit duty is duty low byte plus control bits 5 and 4.
// - After count equals period: clear count, set output unless the new duty is zero, latch duty.
// - Output clears on duty match; duty above period never clears.
// - Half-bridge second output is the delayed complement of the first.
// - Forward holds A active, modulates D; reverse holds C, modulates B.
package bpdd_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_INT_CTRL   = 8'h0B;
    localparam logic [7:0] IDX_FLAGS1     = 8'h0C;
    localparam logic [7:0] IDX_T2_COUNT   = 8'h11;
    localparam logic [7:0] IDX_T2_CTRL    = 8'h12;
    localparam logic [7:0] IDX_DUTY_LO    = 8'h15;
    localparam logic [7:0] IDX_DUTY_LATCH = 8'h16;
    localparam logic [7:0] IDX_PWM_CTRL   = 8'h17;
    localparam logic [7:0] IDX_PORTB_DIR  = 8'h86;
    localparam logic [7:0] IDX_ENABLES1   = 8'h8C;
    localparam logic [7:0] IDX_T2_PERIOD  = 8'h92;
    localparam logic [7:0] IDX_DEADBAND   = 8'h97;

    // Values after reset, and the Timer2 control write mask.
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_ONES    = 8'hFF;
    localparam logic [7:0] T2_CTRL_MSK = 8'h7F;

    // Field positions.
    localparam int FLAG_PERIOD_BIT = 1;
    localparam int T2_RUN_BIT      = 2;
    localparam int PIN_A_DIR_BIT   = 3;
    localparam int PIN_B_DIR_BIT   = 5;
    localparam int PIN_C_DIR_BIT   = 6;
    localparam int PIN_D_DIR_BIT   = 7;

    // Timing: the clock period equals one oscillator period.
    localparam int TOSC_NS    = 50;
    localparam int CLK_NS     = 50;
    localparam int INSTR_TOSC = 4;
    localparam int INSTR_CYC  = INSTR_TOSC * TOSC_NS / CLK_NS;
    localparam int EARLY_TOSC_P1  = 1;
    localparam int EARLY_TOSC_P4  = 4;
    localparam int EARLY_TOSC_P16 = 16;

    // Output modes, taken from the top two bits of the control register.
    typedef enum logic [1:0] {
        MODE_SINGLE   = 2'b00,
        MODE_FULL_FWD = 2'b01,
        MODE_HALF     = 2'b10,
        MODE_FULL_REV = 2'b11
    } bpdd_mode_type;

    // Control register layout.
    typedef struct packed {
        bpdd_mode_type mode;
        logic [1:0]    duty_lsb;
        logic [3:0]    polarity;
    } bpdd_ctrl_type;

    // The four bridge outputs.
    typedef struct packed {
        logic d;
        logic c;
        logic b;
        logic a;
    } bpdd_pins_type;

endpackage

// file: src/bpdd_pwm.sv
// Bridge PWM output stage with Timer2 time base and APB registers.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module bpdd_pwm
    import bpdd_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    // Bridge outputs and their enables.
    output bpdd_pins_type          bridge_out,
    output bpdd_pins_type          bridge_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic [7:0]    int_ctrl_r;
    logic [7:0]    flags1_r;
    logic [7:0]    flags1_nxt;
    logic [7:0]    tmr_r;
    logic [7:0]    t2_ctrl_r;
    logic [7:0]    duty_lo_r;
    logic [7:0]    duty_latch_r;
    logic [1:0]    dl2_r;
    bpdd_ctrl_type ctrl_r;
    logic [7:0]    portb_dir_r;
    logic [7:0]    enables1_r;
    logic [7:0]    period_r;
    logic [7:0]    deadband_r;
    logic [7:0]    rd_mux;
    logic [31:0]   prdata_r;
    logic [1:0]    inst_r;
    logic [5:0]    pre_r;
    logic          pwm_r;
    logic          pwm_d_r;
    logic          primed_r;
    logic          dir_act_r;
    logic          trans_r;
    logic [7:0]    db_cnt_r;
    bpdd_pins_type act_r;
    bpdd_pins_type act_nxt;
    bpdd_pins_type out_r;

    ////////////////////////////////////////////////////////////////////////
    // Address decode helpers.
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == {2'b00, idx});
    endfunction

    // Early switch length in clock cycles for a prescale code.
    function automatic logic [5:0] early_cyc(input logic [1:0] ps);
        int t;
        t = (ps == 2'b00) ? EARLY_TOSC_P1 :
            (ps == 2'b01) ? EARLY_TOSC_P4 : EARLY_TOSC_P16;
        early_cyc = 6'(t * TOSC_NS / CLK_NS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB decode; the slave never waits.
    wire        acc      = psel && penable;
    wire        wr       = acc && pwrite;
    wire        mapped   = hit(paddr, IDX_INT_CTRL) || hit(paddr, IDX_FLAGS1)
                        || hit(paddr, IDX_T2_COUNT) || hit(paddr, IDX_T2_CTRL)
                        || hit(paddr, IDX_DUTY_LO)
                        || hit(paddr, IDX_DUTY_LATCH)
                        || hit(paddr, IDX_PWM_CTRL)
                        || hit(paddr, IDX_PORTB_DIR)
                        || hit(paddr, IDX_ENABLES1)
                        || hit(paddr, IDX_T2_PERIOD)
                        || hit(paddr, IDX_DEADBAND);
    wire [7:0]  wd       = pwdata[7:0];
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = prdata_r;

    // Read selection; the duty latch is read-only.
    assign rd_mux = hit(paddr, IDX_INT_CTRL)   ? int_ctrl_r   :
                    hit(paddr, IDX_FLAGS1)     ? flags1_r     :
                    hit(paddr, IDX_T2_COUNT)   ? tmr_r        :
                    hit(paddr, IDX_T2_CTRL)    ? t2_ctrl_r    :
                    hit(paddr, IDX_DUTY_LO)    ? duty_lo_r    :
                    hit(paddr, IDX_DUTY_LATCH) ? duty_latch_r :
                    hit(paddr, IDX_PWM_CTRL)   ? ctrl_r       :
                    hit(paddr, IDX_PORTB_DIR)  ? portb_dir_r  :
                    hit(paddr, IDX_ENABLES1)   ? enables1_r   :
                    hit(paddr, IDX_T2_PERIOD)  ? period_r     :
                    hit(paddr, IDX_DEADBAND)   ? deadband_r   : RST_ZERO;

    // Read data is captured in the setup cycle so it comes from a flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= '0;
        else if (psel && !penable)
            prdata_r <= {24'h000000, rd_mux};
    end

    ////////////////////////////////////////////////////////////////////////
    // Time base decode.
    wire           run      = t2_ctrl_r[T2_RUN_BIT];
    wire [1:0]     presc    = t2_ctrl_r[1:0];
    wire [5:0]     pre_last = (presc == 2'b00) ? 6'h03 :
                              (presc == 2'b01) ? 6'h0F : 6'h3F;
    wire [5:0]     pre_ely  = pre_last - early_cyc(presc);
    wire [1:0]     fine     = (presc == 2'b00) ? pre_r[1:0] :
                              (presc == 2'b01) ? pre_r[3:2] : pre_r[5:4];
    wire           tick     = run && (pre_r == pre_last);
    wire           wrap     = tick && (tmr_r == period_r);
    wire           match    = {duty_latch_r, dl2_r} == {tmr_r, fine};
    wire           wave     = pwm_r && !(run && match);
    wire [9:0]     duty_new = {duty_lo_r, ctrl_r.duty_lsb};
    wire           instr_en = inst_r == 2'(INSTR_CYC - 1);
    wire           pwm_on   = ctrl_r.polarity[3:2] == 2'b11;
    wire           is_full  = ctrl_r.mode[0];
    wire           is_half  = ctrl_r.mode == MODE_HALF;
    wire           new_dir  = ctrl_r.mode[1];
    wire           early_pt = run && is_full && (tmr_r == period_r)
                              && (pre_r == pre_ely);
    wire           pwm_chg  = wave != pwm_d_r;
    wire [7:0]     db_wait  = pwm_chg ? deadband_r : db_cnt_r;
    wire           db_done  = db_wait == RST_ZERO;
    // The edge cycle counts as well, so the hold never exceeds the count.
    wire [7:0]     db_first = (instr_en && deadband_r != RST_ZERO)
                              ? deadband_r - 8'h01 : deadband_r;
    wire           ac_low   = ctrl_r.polarity[1];
    wire           bd_low   = ctrl_r.polarity[0];
    bpdd_pins_type pol_mask;
    assign pol_mask = '{d: bd_low, c: ac_low, b: bd_low, a: ac_low};

    ////////////////////////////////////////////////////////////////////////
    // Software registers; writes land in the access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_ctrl_r  <= RST_ZERO;
            t2_ctrl_r   <= RST_ZERO;
            duty_lo_r   <= RST_ZERO;
            ctrl_r      <= RST_ZERO;
            portb_dir_r <= RST_ONES;
            enables1_r  <= RST_ZERO;
            period_r    <= RST_ONES;
            deadband_r  <= RST_ZERO;
        end
        else if (wr)
        begin
            if (hit(paddr, IDX_INT_CTRL))  int_ctrl_r  <= wd;
            if (hit(paddr, IDX_T2_CTRL))   t2_ctrl_r   <= wd & T2_CTRL_MSK;
            if (hit(paddr, IDX_DUTY_LO))   duty_lo_r   <= wd;
            if (hit(paddr, IDX_PWM_CTRL))  ctrl_r      <= wd;
            if (hit(paddr, IDX_PORTB_DIR)) portb_dir_r <= wd;
            if (hit(paddr, IDX_ENABLES1))  enables1_r  <= wd;
            if (hit(paddr, IDX_T2_PERIOD)) period_r    <= wd;
            if (hit(paddr, IDX_DEADBAND))  deadband_r  <= wd;
        end
    end

    // Flag register: a cycle end beats a software clear in the same cycle.
    always_comb
    begin
        flags1_nxt = flags1_r;
        if (wr && hit(paddr, IDX_FLAGS1))
            flags1_nxt = wd;
        if (wrap)
            flags1_nxt[FLAG_PERIOD_BIT] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags1_r <= RST_ZERO;
        else
            flags1_r <= flags1_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle divider and Timer2 prescaler.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            inst_r <= 2'b00;
        else
            inst_r <= inst_r + 2'b01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_r <= 6'h00;
        else if (!run || pre_r == pre_last)
            pre_r <= 6'h00;
        else
            pre_r <= pre_r + 6'h01;
    end

    // Timer2 count; a software write overrides the count.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tmr_r <= RST_ZERO;
        else if (wr && hit(paddr, IDX_T2_COUNT))
            tmr_r <= wd;
        else if (wrap)
            tmr_r <= RST_ZERO;
        else if (tick)
            tmr_r <= tmr_r + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM waveform: set at the period end unless the duty is zero, cleared on the duty match.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_r        <= 1'b0;
            duty_latch_r <= RST_ZERO;
            dl2_r        <= 2'b00;
            primed_r     <= 1'b0;
        end
        else if (wrap)
        begin
            pwm_r        <= duty_new != 10'h000;
            duty_latch_r <= duty_lo_r;
            dl2_r        <= ctrl_r.duty_lsb;
            primed_r     <= pwm_on;
        end
        else
        begin
            if (run && match)
                pwm_r <= 1'b0;
            if (!pwm_on)
                primed_r <= 1'b0;
        end
    end

    // In the full-bridge modes direction is picked up only near the period end, so a write in
    // mid-cycle never disturbs the cycle already running; other modes take it every clock.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_act_r <= 1'b0;
            trans_r   <= 1'b0;
        end
        else if (!is_full)
        begin
            dir_act_r <= new_dir;
            trans_r   <= 1'b0;
        end
        else if (early_pt && new_dir != dir_act_r)
        begin
            dir_act_r <= new_dir;
            trans_r   <= 1'b1;
        end
        else if (wrap)
            trans_r <= 1'b0;
    end

    // Deadband counter: loads on each waveform edge, steps per instruction.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_d_r  <= 1'b0;
            db_cnt_r <= RST_ZERO;
        end
        else
        begin
            pwm_d_r <= wave;
            if (pwm_chg)
                db_cnt_r <= db_first;
            else if (instr_en && db_cnt_r != RST_ZERO)
                db_cnt_r <= db_cnt_r - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output steering; everything sits inactive until one cycle has run.
    always_comb
    begin
        act_nxt = '0;
        if (pwm_on && primed_r)
        begin
            unique case (ctrl_r.mode)
                MODE_SINGLE:
                    act_nxt.a = wave;
                MODE_HALF:
                begin
                    act_nxt.a = wave && db_done;
                    act_nxt.b = !wave && db_done;
                end
                MODE_FULL_FWD, MODE_FULL_REV:
                begin
                    // No deadband here: the modulated leg follows wave.
                    act_nxt.a = !dir_act_r;
                    act_nxt.d = !dir_act_r && wave && !trans_r;
                    act_nxt.c = dir_act_r;
                    act_nxt.b = dir_act_r && wave && !trans_r;
                end
            endcase
        end
    end

    // Pin levels apply the polarity after the active-state logic.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act_r <= '0;
            out_r <= '0;
        end
        else
        begin
            act_r <= act_nxt;
            out_r <= pwm_on ? (act_nxt ^ pol_mask) : '0;
        end
    end

    assign bridge_out = out_r;
    // Pin drivers follow the port direction bits, low meaning output.
    assign bridge_oe  = '{d: !portb_dir_r[PIN_D_DIR_BIT],
                          c: !portb_dir_r[PIN_C_DIR_BIT],
                          b: !portb_dir_r[PIN_B_DIR_BIT],
                          a: !portb_dir_r[PIN_A_DIR_BIT]};

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_wrap_clears_count: assert property (wrap && !wr
        |=> tmr_r == 8'h00)
        else $error("Count not cleared after period end.");
    a_duty_latch_load: assert property (wrap |=>
        {duty_latch_r, dl2_r} == $past(duty_new))
        else $error("Duty not latched at period end.");
    a_flag_on_wrap: assert property (wrap |=> flags1_r[FLAG_PERIOD_BIT])
        else $error("Period flag not set at cycle end.");
    a_match_clears_out: assert property (run && match && !wrap
        |=> !pwm_r)
        else $error("Duty match did not clear the waveform.");
    a_full_no_dead: assert property (is_full && pwm_on && primed_r
        && !trans_r && !dir_act_r && $stable(ctrl_r) |=> act_r.d == $past(wave))
        else $error("Full-bridge modulated output delayed.");
    a_trans_inactive: assert property (trans_r |=> !act_r.b && !act_r.d)
        else $error("Modulated output active in transition.");
    a_dir_deferred: assert property (is_full && !early_pt |=>
        $stable(dir_act_r))
        else $error("Direction changed away from the period end.");
    a_early_point: assert property ($rose(trans_r) |->
        tmr_r == period_r && pre_r == 6'(pre_ely + 6'h01))
        else $error("Direction switch not at the early point.");
    a_dead_hold: assert property (is_half && pwm_chg
        && deadband_r != 8'h00 |=> !act_r.a && !act_r.b)
        else $error("Half-bridge edge not held by deadband.");
    a_prime_gate: assert property (!primed_r |=> act_r == '0)
        else $error("Outputs active before first full cycle.");

    c_half_dead: cover property (is_half && pwm_chg && deadband_r != 8'h00);
    c_dir_change: cover property ($rose(trans_r) ##[1:1000] $fell(trans_r));
    c_flag_set: cover property ($rose(flags1_r[FLAG_PERIOD_BIT]));
    c_bad_addr: cover property (pslverr);

endmodule

// file: test/bpdd_switch_model.sv
// Model of the external bridge switch drivers on the four outputs.
`timescale 1ns/10ps
module bpdd_switch_model
    import bpdd_pkg::*;
(
    // Clock and reset.
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Stage pins and their enables.
    input  wire bpdd_pins_type bridge_out,
    input  wire bpdd_pins_type bridge_oe,
    // Gate levels and fault count.
    output bpdd_pins_type      gate,
    output logic [15:0]        shoot_count
);
    ////////////////////////////////////////////////////////////////////////
    // Pull-downs hold an undriven gate low, so its switch stays off.
    assign gate = bpdd_pins_type'(bridge_out & bridge_oe);

    // Both switches of one leg on at once would short the supply.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shoot_count <= 16'h0000;
        else if ((gate.a && gate.b) || (gate.c && gate.d))
            shoot_count <= shoot_count + 16'h0001;
    end
endmodule

// file: test/test_bpdd_pwm.sv
// Self-checking bench for the bridge PWM output stage.
`timescale 1ns/10ps
module test_bpdd_pwm;
    import bpdd_pkg::*;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    bpdd_pins_type bridge_out;
    bpdd_pins_type bridge_oe;
    bpdd_pins_type gate;
    logic [15:0]   shoot_count;
    logic [31:0]   rd;
    logic          err;
    logic          rev;
    int            fail_count;
    int            checks_done;
    int            cnt [4];
    int            n;
    int            idle_bad;
    logic [7:0]    ridx [7];
    logic [7:0]    rval [7];
    logic [7:0]    dlo [4];
    logic [1:0]    dls [4];
    int            dex [4];

    ////////////////////////////////////////////////////////////////////////
    // One clock period equals one oscillator period.
    always #25 pclk = ~pclk;

    bpdd_pwm #(.ADDR_W(12)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .bridge_out(bridge_out),
        .bridge_oe(bridge_oe));

    bpdd_switch_model far_end (
        .pclk(pclk), .presetn(presetn), .bridge_out(bridge_out),
        .bridge_oe(bridge_oe), .gate(gate), .shoot_count(shoot_count));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Compares a value against a window; a single value uses lo = hi.
    task automatic check(input string what, input logic [31:0] lo,
                         input logic [31:0] hi, input logic [31:0] got);
        checks_done++;
        if (!(got >= lo && got <= hi) || $isunknown(got))
        begin
            fail_count++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high.
    // It opens on a fresh edge, so two calls never drive psel in one step.
    task automatic apb(input logic [7:0] idx, input logic wr,
                       input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        apb(idx, 1'b1, wd);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        apb(idx, 1'b0, 8'h00);
        check("register", {24'h0, exp}, {24'h0, exp}, rd);
    endtask

    // Counts high cycles of each output over a span of cycles.
    task automatic measure(input int len);
        for (int k = 0; k < 4; k++)
            cnt[k] = 0;
        repeat (len)
        begin
            @(posedge pclk);
            #1;
            for (int k = 0; k < 4; k++)
                cnt[k] += (bridge_out[k] === 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard, several times the expected length of the run.
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        stop_test();
    end

    // Main sequence; a PWM period is 16 clocks at prescale 00 and period 3.
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        ridx = '{IDX_T2_PERIOD, IDX_T2_COUNT, IDX_DEADBAND, IDX_PORTB_DIR,
                 IDX_PWM_CTRL, IDX_T2_CTRL, IDX_FLAGS1};
        rval = '{RST_ONES, RST_ZERO, RST_ZERO, RST_ONES, RST_ZERO,
                 RST_ZERO, RST_ZERO};
        dlo = '{8'h00, 8'h02, 8'h01, 8'h05};
        dls = '{2'b00, 2'b00, 2'b10, 2'b00};
        dex = '{0, 8, 6, 16};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++)
            rd_chk(ridx[i], rval[i]);
        wr(IDX_DEADBAND, 8'hA5);
        rd_chk(IDX_DEADBAND, 8'hA5);
        apb(8'h40, 1'b0, 8'h00);
        check("unmapped", 32'h1, 32'h1, {rd[30:0], err});
        // Setup order: pins off, period, duty, control, deadband.
        wr(IDX_PORTB_DIR, 8'hFF);
        wr(IDX_T2_PERIOD, 8'h03);
        wr(IDX_DUTY_LO, 8'h02);
        wr(IDX_PWM_CTRL, 8'h8C);
        wr(IDX_DEADBAND, 8'h00);
        wr(IDX_FLAGS1, 8'h00);
        wr(IDX_T2_CTRL, 8'h04);
        n = 0;
        rd = 32'h0;
        while (rd[FLAG_PERIOD_BIT] !== 1'b1 && n < 20)
        begin
            apb(IDX_FLAGS1, 1'b0, 8'h00);
            n++;
        end
        check("period flag", 1, 1, rd[FLAG_PERIOD_BIT]);
        wr(IDX_PORTB_DIR, 8'h17);
        #1;
        check("enables", 15, 15, bridge_oe);
        measure(16);
        check("half a", 8, 8, cnt[0]);
        check("half b", 8, 8, cnt[1]);
        wr(IDX_DEADBAND, 8'h01);
        repeat (32) @(posedge pclk);
        measure(16);
        check("dead a", 4, 7, cnt[0]);
        check("dead b", 4, 7, cnt[1]);
        wr(IDX_PWM_CTRL, 8'h4C);
        repeat (48) @(posedge pclk);
        measure(16);
        check("fwd a", 16, 16, cnt[0]);
        check("fwd bc", 0, 0, cnt[1] + cnt[2]);
        check("fwd d", 8, 8, cnt[3]);
        // Direction changes at prescale codes 00, 01 and 10, away from full duty.
        for (int p = 0; p < 3; p++)
        begin
            wr(IDX_T2_CTRL, 8'h04 | p[7:0]);
            repeat (48 << (2 * p)) @(posedge pclk);
            rev = (p != 1);
            wr(IDX_PWM_CTRL, rev ? 8'hCC : 8'h4C);
            n = 0;
            while ((rev ? bridge_out.c : bridge_out.a) !== 1'b1 && n < 600)
            begin
                @(posedge pclk);
                #1;
                n++;
            end
            check("new side", 0, 599, n);
            n = 0;
            idle_bad = 0;
            while ((rev ? bridge_out.b : bridge_out.d) !== 1'b1 && n < 40)
            begin
                if (bridge_out.b !== 1'b0 || bridge_out.d !== 1'b0)
                    idle_bad++;
                @(posedge pclk);
                #1;
                n++;
            end
            check("early", 1 << (2 * p), 1 << (2 * p), n);
            check("mod idle", 0, 0, idle_bad);
        end
        check("shoot", 0, 0, shoot_count);
        // Duty values in single mode, including zero and above period.
        // Stopping first clears the prescaler, which may sit past 3 now.
        wr(IDX_T2_CTRL, 8'h00);
        wr(IDX_T2_CTRL, 8'h04);
        for (int i = 0; i < 4; i++)
        begin
            wr(IDX_DUTY_LO, dlo[i]);
            wr(IDX_PWM_CTRL, {2'b00, dls[i], 4'hC});
            repeat (48) @(posedge pclk);
            measure(16);
            check("duty", dex[i], dex[i], cnt[0]);
        end
        wr(IDX_DUTY_LO, 8'h01);
        wr(IDX_PWM_CTRL, 8'h2E);
        repeat (48) @(posedge pclk);
        measure(16);
        check("low active", 10, 10, cnt[0]);
        stop_test();
    end
endmodule
